// ### test/dma_chan_chk.sv
/*
 Checker for the DMA channel pair: port relations over time.
 Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/10ps
module dma_chan_chk
(
   // Clock, reset and register port
   input wire logic        clk_i, nrst_i, wr_i, rd_i,
   input wire logic [8:0]  addr_i,
   input wire logic [31:0] wdata_i, rdata_o,
   // Readies, requests and flags
   input wire logic        rx_ready_i, tx_ready_i, rx_req_o, tx_req_o,
   input wire logic        rx_current_done_o, rx_buffers_full_o,
   input wire logic        tx_current_done_o, tx_buffers_exhausted_o
);
   // ==========================================================
   // Shared clocking; reset masks everything
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   // Read data stand one cycle only, zero otherwise
   a_rdata_quiet_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   a_state_shape_bits: assert property ($past(rd_i) &&
      $past(addr_i) == dma_chan_pkg::off_state |-> rdata_o[31:9] == 23'h0 && rdata_o[7:1] == 7'h0)
      else $error("state word has bits beside the two enables");
   // Counts are 16 bits wide, upper half reads zero
   a_count_upper_zero: assert property (rd_i && addr_i[8:5] == 4'h8 &&
      addr_i[2:0] == 3'h4 |=> rdata_o[31:16] == 16'h0)
      else $error("count read shows upper bits");
   // Write then read back of the following pointer echoes the data
   a_next_ptr_echo: assert property (wr_i && addr_i == dma_chan_pkg::off_rx_nxt_ptr ##1
      rd_i && addr_i == dma_chan_pkg::off_rx_nxt_ptr |=> rdata_o == $past(wdata_i, 2))
      else $error("following pointer readback differs");
   // A request only follows a ready from the peripheral
   a_rx_req_cause: assert property ($rose(rx_req_o) |-> $past(rx_ready_i))
      else $error("receive request without ready");
   a_tx_req_cause: assert property ($rose(tx_req_o) |-> $past(tx_ready_i))
      else $error("transmit request without ready");
   // Both-empty flags imply the end flag of the same direction
   a_full_with_done: assert property (rx_buffers_full_o |-> rx_current_done_o)
      else $error("full flag without receive end flag");
   a_empty_with_done: assert property (tx_buffers_exhausted_o |-> tx_current_done_o)
      else $error("exhausted flag without transmit end flag");
endmodule

bind dma_channel_ctrl dma_chan_chk chk (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i),
   .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
   .rx_ready_i(rx_ready_i), .tx_ready_i(tx_ready_i), .rx_req_o(rx_req_o),
   .tx_req_o(tx_req_o), .rx_current_done_o(rx_current_done_o),
   .rx_buffers_full_o(rx_buffers_full_o), .tx_current_done_o(tx_current_done_o),
   .tx_buffers_exhausted_o(tx_buffers_exhausted_o));

// ### test/dma_periph_model.sv
/*
 Peripheral and memory-side model: level readies, one-cycle grants.
 Assumes the channel drops its request after each grant.
*/
`timescale 1ns/10ps
module dma_periph_model
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Requests and bench controls
   input  wire logic rx_req_i,
   input  wire logic tx_req_i,
   input  wire logic on_i,
   input  wire logic slow_i,
   // Readies and grant
   output logic      rx_ready_o,
   output logic      tx_ready_o,
   output logic      mem_grant_o
);
   // ==========================================================
   logic [1:0] cnt;  // Cycles a request has waited

   // Grant after one or three waiting cycles; never two grants in a row
   always_ff @(posedge clk_i)
   begin
      rx_ready_o <= nrst_i & on_i;
      tx_ready_o <= nrst_i & on_i;
      mem_grant_o <= 1'b0;
      if (!nrst_i || !(rx_req_i | tx_req_i) || mem_grant_o)
         cnt <= 2'h0;
      else if (cnt >= (slow_i ? 2'h3 : 2'h1))
      begin
         mem_grant_o <= 1'b1;
         cnt <= 2'h0;
      end
      else
         cnt <= cnt + 2'h1;
   end
endmodule

// ### test/tb_top.sv
/*
 Bench: full and half duplex channels against a register model.
 Assumes 50 MHz clock and a 16-cycle synchronous reset.
*/
`timescale 1ns/10ps
module tb_top;
   // ==========================================================
   logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, on = 0, slow = 0;
   logic [8:0] addr_i = 9'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, rdh, mem_addr_o;
   logic [1:0] size_i = 2'h0, fe = 2'h0, he = 2'h0;  // Model enables, bit 1 transmit
   logic rx_ready_i, tx_ready_i, mem_grant_i, rx_req_o, tx_req_o;
   logic rx_current_done_o, rx_buffers_full_o, tx_current_done_o, tx_buffers_exhausted_o;
   logic [31:0] f [8] = '{default: 32'h0};  // Full duplex register model
   logic [31:0] h [8] = '{default: 32'h0};  // Half duplex: odd pairs unused
   logic [31:0] q [$];                      // Expected memory addresses
   logic [15:0] sd = 16'h5ca3;
   int num_errors = 0, tests_run = 0;

   always #10 clk_i = ~clk_i;

   dma_channel_ctrl dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .rx_ready_i, .tx_ready_i, .size_i, .mem_grant_i, .rx_req_o, .tx_req_o, .mem_addr_o,
      .rx_current_done_o, .rx_buffers_full_o, .tx_current_done_o, .tx_buffers_exhausted_o);
   // Half duplex copy only sees register traffic
   dma_channel_ctrl #(.half_duplex(1'b1)) dut_h (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o(rdh), .rx_ready_i(1'b0), .tx_ready_i(1'b0), .size_i(2'h0),
      .mem_grant_i(1'b0), .rx_req_o(), .tx_req_o(), .mem_addr_o(), .rx_current_done_o(),
      .rx_buffers_full_o(), .tx_current_done_o(), .tx_buffers_exhausted_o());
   dma_periph_model pm (.clk_i, .nrst_i, .rx_req_i(rx_req_o), .tx_req_i(tx_req_o),
      .on_i(on), .slow_i(slow), .rx_ready_o(rx_ready_i), .tx_ready_o(tx_ready_i),
      .mem_grant_o(mem_grant_i));

   // ==========================================================
   function automatic logic [15:0] lf(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected read data for either build
   function automatic logic [31:0] ev(input bit hd, input logic [8:0] a);
      ev = 32'h0;
      if (a == dma_chan_pkg::off_state)
         ev = {23'h0, hd ? he[1] : fe[1], 7'h0, hd ? he[0] : fe[0]};
      else if (a >= 9'h100 && a < 9'h120 && a[1:0] == 2'h0)
         ev = hd ? h[a[4:2] & 3'h5] : f[a[4:2]];
   endfunction

   // Model write: counts keep 16 bits, disable beats enable
   task automatic mw(input logic [8:0] a, input logic [31:0] d);
      logic [31:0] v;
      v = a[2] ? {16'h0, d[15:0]} : d;
      if (a >= 9'h100 && a < 9'h120 && a[1:0] == 2'h0)
      begin
         f[a[4:2]] = v;
         h[a[4:2] & 3'h5] = v;
      end
      if (a == dma_chan_pkg::off_ctrl)
      begin
         if (d[1]) fe[0] = 1'b0; else if (d[0]) fe[0] = 1'b1;
         if (d[9]) fe[1] = 1'b0; else if (d[8]) fe[1] = 1'b1;
         if (d[1] | d[9]) he = 2'h0; else if (d[0]) he = 2'h1; else if (d[8]) he[1] = 1'b1;
      end
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   // Reload model: an empty current count with a nonzero following count
   // takes the following pair over in the cycle after the write
   task automatic rl();
      for (int b = 0; b < 3; b += 2)
         if (f[b + 1] == 32'h0 && f[b + 5] != 32'h0)
         begin
            f[b]     = f[b + 4];
            f[b + 1] = f[b + 5];
            f[b + 4] = 32'h0;
            f[b + 5] = 32'h0;
         end
      if (h[1] == 32'h0 && h[5] != 32'h0)
      begin
         h[0] = h[4];
         h[1] = h[5];
         h[4] = 32'h0;
         h[5] = 32'h0;
      end
   endtask

   // Optional write, then read back the same place on both builds
   task automatic acc(input bit w, input logic [8:0] a, input logic [31:0] d);
      if (w) mw(a, d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk("rdata", ev(1'b0, a), rdata_o);
      chk("rdata_half", ev(1'b1, a), rdh);
      rl();
      @(posedge clk_i);
   endtask

   task automatic dump(input int n);
      for (int i = 0; i < n; i++) acc(1'b0, 9'h100 + 9'(4 * i), 32'h0);
   endtask

   // Bounded wait for a completion flag
   task automatic wf(input bit t);
      int k;
      for (k = 0; k < 300; k++)
      begin
         @(negedge clk_i);
         if ((t ? tx_buffers_exhausted_o : rx_buffers_full_o) === 1'b1) break;
      end
      if (k == 300)
      begin
         chk("flag_wait", 32'h1, 32'h0);
         end_sim;
      end
      @(posedge clk_i);
   endtask

   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Every grant must carry the next expected pointer
   always @(negedge clk_i)
      if (nrst_i && mem_grant_i && (rx_req_o || tx_req_o))
      begin
         if (q.size() == 0) chk("grant", 32'h0, 32'h1);
         else chk("mem_addr", q.pop_front(), mem_addr_o);
      end

   // ==========================================================
   initial
   begin
      logic [8:0] a;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      dump(10);
      repeat (24)
      begin
         sd = lf(sd);
         a = 9'h100 + {4'h0, sd[2:0], 2'h0};
         acc(1'b1, a, {sd, lf(sd)});
         sd = lf(sd);
      end
      acc(1'b1, 9'h128, 32'hffffffff);
      acc(1'b0, 9'h0fc, 32'h0);
      dump(8);
      for (int c = 0; c < 16; c++)
         for (int p = 0; p < 2; p++)
         begin
            // Software never sets both enables together
            if ((c[0] && c[2]) || (p == 0 && c == 4)) continue;
            acc(1'b1, 9'h120, 32'h202);
            acc(1'b1, 9'h120, p ? 32'h100 : 32'h1);
            acc(1'b1, 9'h120, {22'h0, c[3:2], 6'h0, c[1:0]});
            acc(1'b0, 9'h124, 32'h0);
         end
      acc(1'b1, 9'h120, 32'h202);
      acc(1'b1, 9'h100, 32'h1000);
      acc(1'b1, 9'h104, 32'h2);
      acc(1'b1, 9'h110, 32'h2000);
      acc(1'b1, 9'h114, 32'h1);
      q = '{32'h1000, 32'h1004, 32'h2000, 32'h30};
      size_i <= 2'h2;
      on <= 1'b1;
      acc(1'b1, 9'h120, 32'h1);
      wf(1'b0);
      chk("rx_done", 32'h1, rx_current_done_o);
      f[0] = 32'h2004; f[1] = 32'h0; f[4] = 32'h0; f[5] = 32'h0;
      dump(8);
      acc(1'b1, 9'h108, 32'h30);
      acc(1'b1, 9'h10c, 32'h1);
      acc(1'b1, 9'h11c, 32'h0);
      size_i <= 2'h0;
      slow <= 1'b1;
      acc(1'b1, 9'h120, 32'h100);
      wf(1'b1);
      chk("tx_done", 32'h1, tx_current_done_o);
      f[2] = 32'h31; f[3] = 32'h0;
      dump(8);
      chk("grants_left", 32'h0, q.size());
      acc(1'b1, 9'h120, 32'h202);
      acc(1'b1, 9'h104, 32'h5);
      chk("rx_done_clr", 32'h0, rx_current_done_o);
      chk("rx_full_clr", 32'h0, rx_buffers_full_o);
      end_sim;
   end
endmodule

// ### verilog/dma_chan_pkg.sv
/*
 Package of register offsets, field positions and widths for the peripheral
 DMA channel pair. Assumes it is compiled before every design file.
*/
package dma_chan_pkg;
   // ==========================================================
   // Register offsets inside the host peripheral address space
   localparam logic [8:0] off_rx_cur_ptr  = 9'h100;
   localparam logic [8:0] off_rx_cur_cnt  = 9'h104;
   localparam logic [8:0] off_tx_cur_ptr  = 9'h108;
   localparam logic [8:0] off_tx_cur_cnt  = 9'h10c;
   localparam logic [8:0] off_rx_nxt_ptr  = 9'h110;
   localparam logic [8:0] off_rx_nxt_cnt  = 9'h114;
   localparam logic [8:0] off_tx_nxt_ptr  = 9'h118;
   localparam logic [8:0] off_tx_nxt_cnt  = 9'h11c;
   localparam logic [8:0] off_ctrl        = 9'h120;
   localparam logic [8:0] off_state       = 9'h124;
   // ==========================================================
   // Field positions in control and state registers
   localparam int bit_rx_en   = 0;
   localparam int bit_rx_dis  = 1;
   localparam int bit_tx_en   = 8;
   localparam int bit_tx_dis  = 9;
   // ==========================================================
   // Widths and reset values
   localparam int addr_w      = 9;
   localparam int cnt_w       = 16;
   localparam logic [31:0] reset_word = 32'h0;
   localparam logic [15:0] cnt_zero   = 16'h0;
   // Item size codes: byte, half-word, word
   localparam logic [1:0] size_byte = 2'h0;
   localparam logic [1:0] size_half = 2'h1;
   localparam logic [1:0] size_word = 2'h2;
endpackage

// ### verilog/dma_channel_ctrl.sv
/*
 Peripheral DMA channel pair: register file, request enables and the
 receive/transmit counter lanes. Assumes the host peripheral gives ready
 pulses and a memory side that takes one item per grant on the same clock.
*/
// Behaviour
// - ten registers 0x100..0x124, reset to zero
// - receive pointer holds full address
// - zero receive count halts receive
// - transmit pointer holds full address
// - zero transmit count halts transmit
// - following receive pointer and count
// - following transmit pointer and count
// - half duplex shares one storage set
// - bit 0 enables receive unless disable
// - bit 1 disables receive
// - bit 8 enables transmit
// - bit 9 disables transmit
// - half duplex receive enable clears transmit
// - half duplex transmit enable needs no rx
// - half duplex rx disable clears both
// - half duplex tx disable clears both
// - empty current reloads from following pair
// - pointer steps 1, 2 or 4
// - done and exhausted flags to peripheral
// - status bits 0 and 8 show enables
`timescale 1ns/10ps
module dma_channel_ctrl
#(
   parameter bit half_duplex = 1'b0,  // One shared channel when set
   parameter int cnt_w       = 16     // Counter width
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Register port
   input  wire logic [8:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Peripheral readies and item size
   input  wire logic        rx_ready_i,
   input  wire logic        tx_ready_i,
   input  wire logic [1:0]  size_i,
   // Memory side handshake
   input  wire logic        mem_grant_i,
   output logic             rx_req_o,
   output logic             tx_req_o,
   output logic      [31:0] mem_addr_o,
   // Flags toward the peripheral status register
   output logic             rx_current_done_o,
   output logic             rx_buffers_full_o,
   output logic             tx_current_done_o,
   output logic             tx_buffers_exhausted_o
);
   // ==========================================================
   // Address decode
   wire logic sel_rcp = wr_i && addr_i == dma_chan_pkg::off_rx_cur_ptr;
   wire logic sel_rcc = wr_i && addr_i == dma_chan_pkg::off_rx_cur_cnt;
   wire logic sel_tcp = wr_i && addr_i == dma_chan_pkg::off_tx_cur_ptr;
   wire logic sel_tcc = wr_i && addr_i == dma_chan_pkg::off_tx_cur_cnt;
   wire logic sel_rnp = wr_i && addr_i == dma_chan_pkg::off_rx_nxt_ptr;
   wire logic sel_rnc = wr_i && addr_i == dma_chan_pkg::off_rx_nxt_cnt;
   wire logic sel_tnp = wr_i && addr_i == dma_chan_pkg::off_tx_nxt_ptr;
   wire logic sel_tnc = wr_i && addr_i == dma_chan_pkg::off_tx_nxt_cnt;
   wire logic sel_ctl = wr_i && addr_i == dma_chan_pkg::off_ctrl;

   // Control bits of this write
   wire logic w_rx_en  = sel_ctl && wdata_i[dma_chan_pkg::bit_rx_en];
   wire logic w_rx_dis = sel_ctl && wdata_i[dma_chan_pkg::bit_rx_dis];
   wire logic w_tx_en  = sel_ctl && wdata_i[dma_chan_pkg::bit_tx_en];
   wire logic w_tx_dis = sel_ctl && wdata_i[dma_chan_pkg::bit_tx_dis];

   // ==========================================================
   // Request enables
   logic rx_request_enable;  // Receive requests allowed
   logic tx_request_enable;  // Transmit requests allowed
   logic next_rx_en;
   logic next_tx_en;

   // Enable update; zero bits have no effect
   always_comb
   begin
      next_rx_en = rx_request_enable;
      next_tx_en = tx_request_enable;
      if (half_duplex)
      begin
         if (w_rx_en)
         begin
            next_rx_en = 1'b1;
            next_tx_en = 1'b0;
         end
         else if (w_tx_en)
            next_tx_en = 1'b1;
         if (w_rx_dis || w_tx_dis)
         begin
            next_rx_en = 1'b0;
            next_tx_en = 1'b0;
         end
      end
      else
      begin
         if (w_rx_en)
            next_rx_en = 1'b1;
         if (w_rx_dis)
            next_rx_en = 1'b0;
         if (w_tx_en)
            next_tx_en = 1'b1;
         if (w_tx_dis)
            next_tx_en = 1'b0;
      end
   end

   // Enable flops
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rx_request_enable <= 1'b0;
         tx_request_enable <= 1'b0;
      end
      else
      begin
         rx_request_enable <= next_rx_en;
         tx_request_enable <= next_tx_en;
      end
   end

   // ==========================================================
   // Lanes; in half duplex both register names load lane 0
   wire logic [31:0]      r_cp, r_np, t_cp, t_np;
   wire logic [cnt_w-1:0] r_cc, r_nc, t_cc, t_nc;
   wire logic             r_done, r_exh, t_done, t_exh;
   wire logic             rx_item;
   wire logic             tx_item;

   // Item moves when a request is granted
   assign rx_item = rx_req_o && mem_grant_i;
   assign tx_item = tx_req_o && mem_grant_i && !rx_req_o;

   wire logic l_cp = sel_rcp || (half_duplex && sel_tcp);
   wire logic l_cc = sel_rcc || (half_duplex && sel_tcc);
   wire logic l_np = sel_rnp || (half_duplex && sel_tnp);
   wire logic l_nc = sel_rnc || (half_duplex && sel_tnc);

   dma_lane #(.cnt_w(cnt_w)) u_rx
   (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .ld_cur_ptr_i (l_cp),
      .ld_cur_cnt_i (l_cc),
      .ld_nxt_ptr_i (l_np),
      .ld_nxt_cnt_i (l_nc),
      .wdata_i      (wdata_i),
      .item_i       (half_duplex ? (rx_item || tx_item) : rx_item),
      .size_i       (size_i),
      .cur_ptr_o    (r_cp),
      .cur_cnt_o    (r_cc),
      .nxt_ptr_o    (r_np),
      .nxt_cnt_o    (r_nc),
      .done_o       (r_done),
      .exhausted_o  (r_exh)
   );

   dma_lane #(.cnt_w(cnt_w)) u_tx
   (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .ld_cur_ptr_i (sel_tcp && !half_duplex),
      .ld_cur_cnt_i (sel_tcc && !half_duplex),
      .ld_nxt_ptr_i (sel_tnp && !half_duplex),
      .ld_nxt_cnt_i (sel_tnc && !half_duplex),
      .wdata_i      (wdata_i),
      .item_i       (tx_item && !half_duplex),
      .size_i       (size_i),
      .cur_ptr_o    (t_cp),
      .cur_cnt_o    (t_cc),
      .nxt_ptr_o    (t_np),
      .nxt_cnt_o    (t_nc),
      .done_o       (t_done),
      .exhausted_o  (t_exh)
   );

   // Effective transmit view: the shared lane in half duplex
   wire logic [31:0]      e_tcp = half_duplex ? r_cp : t_cp;
   wire logic [31:0]      e_tnp = half_duplex ? r_np : t_np;
   wire logic [cnt_w-1:0] e_tcc = half_duplex ? r_cc : t_cc;
   wire logic [cnt_w-1:0] e_tnc = half_duplex ? r_nc : t_nc;

   // ==========================================================
   // Request generation
   // zero receive count halts
   wire logic want_rx = rx_request_enable && rx_ready_i && r_cc != dma_chan_pkg::cnt_zero;
   wire logic want_tx = tx_request_enable && tx_ready_i && e_tcc != dma_chan_pkg::cnt_zero;

   // Requests are registered from want_rx and want_tx each cycle, receive first; a request drops for
   // one cycle after each grant so the count seen next is already decremented
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rx_req_o   <= 1'b0;
         tx_req_o   <= 1'b0;
         mem_addr_o <= dma_chan_pkg::reset_word;
      end
      else
      begin
         rx_req_o   <= want_rx && !(rx_item || tx_item);
         tx_req_o   <= want_tx && !(rx_item || tx_item) && !want_rx;
         mem_addr_o <= want_rx ? r_cp : e_tcp;
      end
   end

   // ==========================================================
   // Read mux; control register is write-only and reads zero
   // register map
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = dma_chan_pkg::reset_word;
      unique case (addr_i)
         dma_chan_pkg::off_rx_cur_ptr: rd_mux = r_cp;
         dma_chan_pkg::off_rx_cur_cnt: rd_mux = 32'(r_cc);
         dma_chan_pkg::off_tx_cur_ptr: rd_mux = e_tcp;
         dma_chan_pkg::off_tx_cur_cnt: rd_mux = 32'(e_tcc);
         dma_chan_pkg::off_rx_nxt_ptr: rd_mux = r_np;
         dma_chan_pkg::off_rx_nxt_cnt: rd_mux = 32'(r_nc);
         dma_chan_pkg::off_tx_nxt_ptr: rd_mux = e_tnp;
         dma_chan_pkg::off_tx_nxt_cnt: rd_mux = 32'(e_tnc);
         dma_chan_pkg::off_state:
         begin
            rd_mux[dma_chan_pkg::bit_rx_en] = rx_request_enable;
            rd_mux[dma_chan_pkg::bit_tx_en] = tx_request_enable;
         end
         default: rd_mux = dma_chan_pkg::reset_word;
      endcase
   end

   // Read data and flags registered
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rdata_o                <= dma_chan_pkg::reset_word;
         rx_current_done_o      <= 1'b0;
         rx_buffers_full_o      <= 1'b0;
         tx_current_done_o      <= 1'b0;
         tx_buffers_exhausted_o <= 1'b0;
      end
      else
      begin
         rdata_o <= rd_i ? rd_mux : dma_chan_pkg::reset_word;
         rx_current_done_o      <= r_done;
         rx_buffers_full_o      <= r_exh;
         tx_current_done_o      <= half_duplex ? r_done : t_done;
         tx_buffers_exhausted_o <= half_duplex ? r_exh : t_exh;
      end
   end
endmodule

// ### verilog/dma_lane.sv
/*
 One direction's current/following counter pair with done and exhausted
 flags. Assumes the register file hands it loads and the peripheral a ready.
*/
`timescale 1ns/10ps
module dma_lane
#(
   parameter int cnt_w = 16
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Software loads
   input  wire logic             ld_cur_ptr_i,
   input  wire logic             ld_cur_cnt_i,
   input  wire logic             ld_nxt_ptr_i,
   input  wire logic             ld_nxt_cnt_i,
   input  wire logic [31:0]      wdata_i,
   // One item moved this cycle
   input  wire logic             item_i,
   input  wire logic [1:0]       size_i,
   // State
   output logic      [31:0]      cur_ptr_o,
   output logic      [cnt_w-1:0] cur_cnt_o,
   output logic      [31:0]      nxt_ptr_o,
   output logic      [cnt_w-1:0] nxt_cnt_o,
   output logic                  done_o,
   output logic                  exhausted_o
);
   // ==========================================================
   // Next-value logic
   wire logic [31:0]      adv_ptr;    // Pointer after one item
   wire logic [cnt_w-1:0] dec_cnt;    // Count after one item
   wire logic             last_item;  // Item empties current count
   wire logic             reload;     // Following pair moves in
   wire logic             nz_load;    // Nonzero count written
   assign dec_cnt   = cur_cnt_o - cnt_w'(1);
   assign last_item = item_i && (cur_cnt_o == cnt_w'(1));
   assign reload    = (last_item || (cur_cnt_o == '0 && !ld_cur_cnt_i)) &&
                      (nxt_cnt_o != '0) && !ld_nxt_cnt_i;
   assign nz_load   = (ld_cur_cnt_i || ld_nxt_cnt_i) && (wdata_i[cnt_w-1:0] != '0);

   dma_ptr_step u_step
   (
      .ptr_i  (cur_ptr_o),
      .size_i (size_i),
      .ptr_o  (adv_ptr)
   );

   // Current and following pointers and counts
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         cur_ptr_o <= '0;
         cur_cnt_o <= '0;
         nxt_ptr_o <= '0;
         nxt_cnt_o <= '0;
      end
      else
      begin
         // Software write wins over the running transfer
         if (ld_cur_ptr_i)
            cur_ptr_o <= wdata_i;
         else if (reload)
            cur_ptr_o <= nxt_ptr_o;
         else if (item_i && cur_cnt_o != '0)
            cur_ptr_o <= adv_ptr;
         if (ld_cur_cnt_i)
            cur_cnt_o <= wdata_i[cnt_w-1:0];
         else if (reload)
            cur_cnt_o <= nxt_cnt_o;
         else if (item_i && cur_cnt_o != '0)
            cur_cnt_o <= dec_cnt;
         if (ld_nxt_ptr_i)
            nxt_ptr_o <= wdata_i;
         else if (reload)
            nxt_ptr_o <= '0;
         if (ld_nxt_cnt_i)
            nxt_cnt_o <= wdata_i[cnt_w-1:0];
         else if (reload)
            nxt_cnt_o <= '0;
      end
   end

   // Flags: set on emptying wins over a clearing count write
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         done_o      <= 1'b0;
         exhausted_o <= 1'b0;
      end
      else
      begin
         done_o      <= last_item || (done_o && !nz_load);
         exhausted_o <= (last_item && nxt_cnt_o == '0) || (exhausted_o && !nz_load);
      end
   end
endmodule

// ### verilog/dma_ptr_step.sv
/*
 Pointer advance unit: adds the item size in bytes to a memory pointer.
 Assumes a purely combinational use inside the channel datapath.
*/
`timescale 1ns/10ps
module dma_ptr_step
(
   // Pointer in and size code
   input  wire logic [31:0] ptr_i,
   input  wire logic [1:0]  size_i,
   // Advanced pointer
   output logic      [31:0] ptr_o
);
   // ==========================================================
   // Step select
   // Byte steps 1, half-word 2, word 4; an unused code steps by a word
   wire logic [31:0] step;
   assign step = (size_i == dma_chan_pkg::size_byte) ? 32'h1 :
                 (size_i == dma_chan_pkg::size_half) ? 32'h2 : 32'h4;
   assign ptr_o = ptr_o_sum(ptr_i, step);

   // Wrapping sum, the carry out is dropped on purpose
   function automatic logic [31:0] ptr_o_sum(input logic [31:0] a, input logic [31:0] b);
      ptr_o_sum = a + b;
   endfunction
endmodule
